// [common/lsp_cfg.svh]
// constants for the lvds sample input port
//
// What this block does
// - capture data lanes on both word clock edges
// - msb lane 15 word mode, 7 byte mode
// - bus order flip reverses lane order first
// - frame rising sample resets fifo or syncs
// - frame falling sample may serve as parity
// - parity lane optional, ignored when unchecked
// - converter clock rise samples strobe, aligns pointers
// - transmit on when gate bit or pin high
// - transmit off forces datapath zero, drops input
// - alarm active high, polarity bit inverts it
// - chip reset returns programming bits to default
// - sleep pin powers down with no clock
`ifndef LSP_CFG_SVH
`define LSP_CFG_SVH
`define LSP_LANES        16
`define LSP_BYTE_MSB     7
`define LSP_PTR_W        3
`define LSP_DIV_W        2
`define LSP_RST_WORD     1'b0
`define LSP_RST_REV      1'b0
`define LSP_RST_TXGATE   1'b0
`define LSP_RST_ALMPOL   1'b0
`define LSP_RST_PCHK     1'b0
`define LSP_RST_BPAR     1'b0
`define LSP_RST_FRMODE   1'b0
`define LSP_RST_DUALSYNC 1'b0
`endif

// [common/lsp_pkg.sv]
// types shared by the lvds sample input port
package lsp_pkg;
  typedef enum logic [1:0] {
    LSP_FR_FIFO_RESET = 2'b01,
    LSP_FR_SYNC       = 2'b10
  } lsp_frame_use_t;
  typedef logic [15:0] lsp_word_t;
endpackage

// [common/lsp_cap_if.sv]
// captured lane samples from the pin capture stage to the core
`timescale 1ns/1ps
`default_nettype none
interface lsp_cap_if;
  logic [15:0] lanes;
  logic        rise_stb;
  logic        fall_stb;
  logic        frame_bit;
  logic        parity_bit;
  logic        sync_bit;
  modport cap  (output lanes, rise_stb, fall_stb, frame_bit, parity_bit,
                output sync_bit);
  modport core (input lanes, rise_stb, fall_stb, frame_bit, parity_bit,
                input sync_bit);
endinterface
`default_nettype wire

// [src/lsp_pin_capture.sv]
// double edge pin capture of lanes, frame, parity and sync
`timescale 1ns/1ps
`default_nettype none
module lsp_pin_capture
  import lsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        input_word_clock,
  input  wire logic [15:0] data_lanes,
  input  wire logic        frame_marker,
  input  wire logic        parity_lane,
  input  wire logic        sync_lane,
  lsp_cap_if.cap           cap
);
  // ****************************************
  // synchronisers
  // ****************************************
  // the word clock is oversampled; it must run well below clk/4
  logic [19:0] s1_q;
  logic [19:0] s2_q;
  logic        wclk_prev_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= 20'h00000;
      s2_q <= 20'h00000;
    end
    else
    begin
      s1_q <= {input_word_clock, sync_lane, parity_lane, frame_marker,
               data_lanes};
      s2_q <= s1_q;
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wclk_prev_q <= 1'b0;
    else
      wclk_prev_q <= s2_q[19];
  end
  // ****************************************
  // edge capture
  // ****************************************
  logic rise_d;
  logic fall_d;
  assign rise_d = s2_q[19] & ~wclk_prev_q;
  assign fall_d = ~s2_q[19] & wclk_prev_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cap.lanes      <= 16'h0000;
      cap.frame_bit  <= 1'b0;
      cap.parity_bit <= 1'b0;
      cap.sync_bit   <= 1'b0;
    end
    else if (rise_d || fall_d)
    begin
      cap.lanes      <= s2_q[15:0];
      cap.frame_bit  <= s2_q[16];
      cap.parity_bit <= s2_q[17];
      cap.sync_bit   <= s2_q[18];
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cap.rise_stb <= 1'b0;
      cap.fall_stb <= 1'b0;
    end
    else
    begin
      cap.rise_stb <= rise_d;
      cap.fall_stb <= fall_d;
    end
  end
  chk_rise_capture: assert property (@(posedge clk) disable iff (!rst_b)
    (s2_q[19] && !wclk_prev_q) |=> cap.rise_stb && !cap.fall_stb
      && cap.lanes == $past(s2_q[15:0]))
    else $error("rising word clock edge not captured");
  chk_fall_capture: assert property (@(posedge clk) disable iff (!rst_b)
    (!s2_q[19] && wclk_prev_q) |=> cap.fall_stb
      && cap.frame_bit == $past(s2_q[16]))
    else $error("falling word clock edge not captured");
endmodule
`default_nettype wire

// [src/lsp_strobe_align.sv]
// converter clock side: strobe sampling, divider and read pointer
`timescale 1ns/1ps
`include "lsp_cfg.svh"
`default_nettype none
module lsp_strobe_align
  import lsp_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      converter_clock,
  input  wire logic                      output_strobe,
  input  wire logic                      dual_sync,
  output logic [`LSP_PTR_W-1:0]          rd_ptr_q,
  output logic [`LSP_DIV_W-1:0]          div_phase_q,
  output logic                           align_q
);
  // ****************************************
  // synchronisers and edge
  // ****************************************
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic       cclk_prev_q;
  logic       cclk_rise;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q        <= 2'h0;
      s2_q        <= 2'h0;
      cclk_prev_q <= 1'b0;
    end
    else
    begin
      s1_q        <= {converter_clock, output_strobe};
      s2_q        <= s1_q;
      cclk_prev_q <= s2_q[1];
    end
  end
  assign cclk_rise = s2_q[1] & ~cclk_prev_q;
  // ****************************************
  // divider and read pointer
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_phase_q <= '0;
      rd_ptr_q    <= '0;
      align_q     <= 1'b0;
    end
    else
    begin
      align_q <= cclk_rise & s2_q[0] & dual_sync;
      if (cclk_rise && s2_q[0] && dual_sync)
      begin
        div_phase_q <= '0;
        rd_ptr_q    <= '0;
      end
      else if (cclk_rise)
      begin
        div_phase_q <= div_phase_q + 1'b1;
        if (div_phase_q == {`LSP_DIV_W{1'b1}})
          rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
  chk_strobe_align: assert property (@(posedge clk) disable iff (!rst_b)
    (cclk_rise && s2_q[0] && dual_sync) |=> align_q
      && rd_ptr_q == 3'h0 && div_phase_q == 2'h0)
    else $error("output strobe did not realign pointers");
  chk_strobe_single: assert property (@(posedge clk) disable iff (!rst_b)
    !dual_sync |=> !align_q)
    else $error("strobe aligned outside dual sync mode");
endmodule
`default_nettype wire

// [src/lsp_lvds_rx.sv]
// lvds sample input port: configuration, assembly, gating, checks
`timescale 1ns/1ps
`include "lsp_cfg.svh"
`default_nettype none
module lsp_lvds_rx
  import lsp_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 input_word_clock,
  input  wire logic [15:0]          data_lanes,
  input  wire logic                 frame_marker,
  input  wire logic                 parity_lane,
  input  wire logic                 sync_lane,
  input  wire logic                 converter_clock,
  input  wire logic                 output_strobe,
  input  wire logic                 chip_reset_n,
  input  wire logic                 sleep_pin,
  input  wire logic                 tx_gate_pin,
  input  wire logic                 cfg_load,
  input  wire logic                 cfg_word_mode,
  input  wire logic                 cfg_rev_bus,
  input  wire logic                 cfg_tx_gate,
  input  wire logic                 cfg_alarm_low,
  input  wire logic                 cfg_parity_chk,
  input  wire logic                 cfg_block_par,
  input  wire logic                 cfg_frame_sync,
  input  wire logic                 cfg_dual_sync,
  input  wire logic                 alarm_clear,
  output lsp_word_t                 i_sample_q,
  output lsp_word_t                 q_sample_q,
  output logic                      sample_valid_q,
  output logic                      fifo_reset_q,
  output logic                      sync_event_q,
  output logic [`LSP_PTR_W-1:0]     wr_ptr_q,
  output logic [`LSP_PTR_W-1:0]     rd_ptr,
  output logic [`LSP_DIV_W-1:0]     div_phase,
  output logic                      strobe_align,
  output logic                      parity_err_q,
  output logic                      tx_active,
  output logic                      alarm_pin,
  output logic                      power_down
);
  lsp_cap_if cap_bus ();

  lsp_pin_capture u_cap (
    .clk              (clk),
    .rst_b            (rst_b),
    .input_word_clock (input_word_clock),
    .data_lanes       (data_lanes),
    .frame_marker     (frame_marker),
    .parity_lane      (parity_lane),
    .sync_lane        (sync_lane),
    .cap              (cap_bus.cap)
  );

  logic dual_sync_q;
  lsp_strobe_align u_align (
    .clk             (clk),
    .rst_b           (rst_b),
    .converter_clock (converter_clock),
    .output_strobe   (output_strobe),
    .dual_sync       (dual_sync_q),
    .rd_ptr_q        (rd_ptr),
    .div_phase_q     (div_phase),
    .align_q         (strobe_align)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] ps1_q;
  logic [1:0] ps2_q;
  logic       chip_rst_n_s;
  logic       tx_pin_s;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // chip reset pin idles high, so no spurious chip reset after rst_b
      ps1_q <= 2'h2;
      ps2_q <= 2'h2;
    end
    else
    begin
      ps1_q <= {chip_reset_n, tx_gate_pin};
      ps2_q <= ps1_q;
    end
  end
  assign chip_rst_n_s = ps2_q[1];
  assign tx_pin_s     = ps2_q[0];

  // ****************************************
  // programming bits
  // ****************************************
  logic word_mode_q;
  logic rev_bus_q;
  logic tx_gate_q;
  logic alarm_low_q;
  logic parity_chk_q;
  logic block_par_q;
  lsp_frame_use_t frame_use_q;
  // chip reset acts on the clock, so a reset held under one clk is lost if no clk rising edge falls inside it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_mode_q  <= `LSP_RST_WORD;
      rev_bus_q    <= `LSP_RST_REV;
      tx_gate_q    <= `LSP_RST_TXGATE;
      alarm_low_q  <= `LSP_RST_ALMPOL;
      parity_chk_q <= `LSP_RST_PCHK;
      block_par_q  <= `LSP_RST_BPAR;
      frame_use_q  <= LSP_FR_FIFO_RESET;
      dual_sync_q  <= `LSP_RST_DUALSYNC;
    end
    else if (!chip_rst_n_s)
    begin
      word_mode_q  <= `LSP_RST_WORD;
      rev_bus_q    <= `LSP_RST_REV;
      tx_gate_q    <= `LSP_RST_TXGATE;
      alarm_low_q  <= `LSP_RST_ALMPOL;
      parity_chk_q <= `LSP_RST_PCHK;
      block_par_q  <= `LSP_RST_BPAR;
      frame_use_q  <= LSP_FR_FIFO_RESET;
      dual_sync_q  <= `LSP_RST_DUALSYNC;
    end
    else if (cfg_load)
    begin
      word_mode_q  <= cfg_word_mode;
      rev_bus_q    <= cfg_rev_bus;
      tx_gate_q    <= cfg_tx_gate;
      alarm_low_q  <= cfg_alarm_low;
      parity_chk_q <= cfg_parity_chk;
      block_par_q  <= cfg_block_par;
      frame_use_q  <= cfg_frame_sync ? LSP_FR_SYNC : LSP_FR_FIFO_RESET;
      dual_sync_q  <= cfg_dual_sync;
    end
  end

  // ****************************************
  // lane order and word assembly
  // ****************************************
  lsp_word_t lanes_rev;
  lsp_word_t lanes_use;
  genvar gi;
  generate
    for (gi = 0; gi < `LSP_LANES; gi++)
    begin : g_rev
      // byte mode mirrors only lanes 7..0, upper lanes read as zero
      if (gi <= `LSP_BYTE_MSB)
        assign lanes_rev[gi] = word_mode_q ?
          cap_bus.lanes[`LSP_LANES-1-gi] : cap_bus.lanes[`LSP_BYTE_MSB-gi];
      else
        assign lanes_rev[gi] = word_mode_q ?
          cap_bus.lanes[`LSP_LANES-1-gi] : 1'b0;
    end
  endgenerate
  always_comb
  begin
    lanes_use = rev_bus_q ? lanes_rev : cap_bus.lanes;
    if (!word_mode_q)
      lanes_use[15:8] = 8'h00;
  end

  assign tx_active = tx_gate_q | tx_pin_s;

  // byte mode: high byte on the rise, low byte on the fall, then i, q
  logic [7:0] hi_byte_q;
  logic       byte_q_sel_q;
  logic       frame_rise;
  logic       frame_fall;
  assign frame_rise = cap_bus.rise_stb & cap_bus.frame_bit;
  assign frame_fall = cap_bus.fall_stb;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      i_sample_q     <= 16'h0000;
      q_sample_q     <= 16'h0000;
      hi_byte_q      <= 8'h00;
      byte_q_sel_q   <= 1'b0;
      sample_valid_q <= 1'b0;
    end
    else if (!tx_active)
    begin
      i_sample_q     <= 16'h0000;
      q_sample_q     <= 16'h0000;
      hi_byte_q      <= 8'h00;
      byte_q_sel_q   <= 1'b0;
      sample_valid_q <= 1'b0;
    end
    else
    begin
      sample_valid_q <= 1'b0;
      if (frame_rise)
        byte_q_sel_q <= 1'b0;
      if (word_mode_q)
      begin
        if (cap_bus.rise_stb)
          i_sample_q <= lanes_use;
        if (cap_bus.fall_stb)
        begin
          q_sample_q     <= lanes_use;
          sample_valid_q <= 1'b1;
        end
      end
      else
      begin
        if (cap_bus.rise_stb)
          hi_byte_q <= lanes_use[`LSP_BYTE_MSB:0];
        if (cap_bus.fall_stb)
        begin
          byte_q_sel_q <= ~byte_q_sel_q;
          if (byte_q_sel_q)
          begin
            q_sample_q     <= {hi_byte_q, lanes_use[7:0]};
            sample_valid_q <= 1'b1;
          end
          else
            i_sample_q <= {hi_byte_q, lanes_use[7:0]};
        end
      end
    end
  end

  // ****************************************
  // frame marker: fifo reset or sync source
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fifo_reset_q <= 1'b0;
      sync_event_q <= 1'b0;
      wr_ptr_q     <= '0;
    end
    else
    begin
      fifo_reset_q <= frame_rise && frame_use_q == LSP_FR_FIFO_RESET;
      sync_event_q <= frame_rise && frame_use_q == LSP_FR_SYNC;
      if (frame_rise && frame_use_q == LSP_FR_FIFO_RESET)
        wr_ptr_q <= '0;
      else if (tx_active && cap_bus.fall_stb)
        wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  // ****************************************
  // parity checks and alarm
  // ****************************************
  // block parity covers the rise word and the fall word of one cycle
  logic rise_par_q;
  logic block_bad;
  logic lane_bad;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rise_par_q <= 1'b0;
    else if (cap_bus.rise_stb)
      rise_par_q <= ^cap_bus.lanes;
  end
  assign block_bad = frame_fall && block_par_q && tx_active &&
    (cap_bus.frame_bit != (rise_par_q ^ (^cap_bus.lanes)));
  // the parity lane is only looked at when checking is on
  assign lane_bad = (cap_bus.rise_stb || cap_bus.fall_stb) &&
    parity_chk_q && tx_active &&
    (cap_bus.parity_bit != (^lanes_use));
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      parity_err_q <= 1'b0;
    else if (block_bad || lane_bad)
      parity_err_q <= 1'b1;
    else if (alarm_clear || !chip_rst_n_s)
      parity_err_q <= 1'b0;
  end
  assign alarm_pin = parity_err_q ^ alarm_low_q;

  // sleep bypasses every flop so it works with no clock at all
  assign power_down = sleep_pin;

  // ****************************************
  // checks
  // ****************************************
  chk_tx_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !tx_active |=> i_sample_q == 16'h0000 && q_sample_q == 16'h0000
      && !sample_valid_q)
    else $error("datapath not zero while transmit is off");
  chk_tx_or: assert property (@(posedge clk) disable iff (!rst_b)
    (tx_gate_q || tx_pin_s) |-> tx_active)
    else $error("transmit off although gate bit or pin is high");
  chk_frame_fifo: assert property (@(posedge clk) disable iff (!rst_b)
    (frame_rise && frame_use_q == LSP_FR_FIFO_RESET)
      |=> fifo_reset_q && wr_ptr_q == 3'h0 && !sync_event_q)
    else $error("frame marker did not reset the fifo");
  chk_block_par: assert property (@(posedge clk) disable iff (!rst_b)
    block_bad |=> parity_err_q)
    else $error("block parity error not flagged");
  chk_lane_par: assert property (@(posedge clk) disable iff (!rst_b)
    !parity_chk_q && !block_par_q && !parity_err_q
      |=> !parity_err_q)
    else $error("parity flagged with checking off");
  chk_alarm_pol: assert property (@(posedge clk) disable iff (!rst_b)
    (!parity_err_q && !alarm_low_q) |-> !alarm_pin)
    else $error("alarm not active high by default");
  chk_chip_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !chip_rst_n_s |=> !tx_gate_q && !rev_bus_q && !alarm_low_q
      && frame_use_q == LSP_FR_FIFO_RESET)
    else $error("chip reset left programming bits set");
  chk_word_msb: assert property (@(posedge clk) disable iff (!rst_b)
    (cap_bus.rise_stb && word_mode_q && !rev_bus_q && tx_active)
      |=> i_sample_q[15] == $past(cap_bus.lanes[15]))
    else $error("lane 15 not msb in word mode");
  chk_rev_lsb: assert property (@(posedge clk) disable iff (!rst_b)
    (cap_bus.rise_stb && word_mode_q && rev_bus_q && tx_active)
      |=> i_sample_q[0] == $past(cap_bus.lanes[15]))
    else $error("bus order flip not applied");
  chk_sleep: assert property (@(posedge clk) disable iff (!rst_b)
    sleep_pin |-> power_down)
    else $error("sleep pin did not power down");
endmodule
`default_nettype wire

// [tb/lsp_src_model.sv]
// data source model driving the lvds sample lanes in ddr framing
`timescale 1ns/1ps
`default_nettype none
module lsp_src_model
  import lsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        send,
  input  wire lsp_word_t   word_r,
  input  wire lsp_word_t   word_f,
  input  wire logic        frame_r,
  input  wire logic        frame_f,
  input  wire logic        bad_par,
  output logic             busy,
  output logic             input_word_clock,
  output logic [15:0]      data_lanes,
  output logic             frame_marker,
  output logic             parity_lane
);
  // ****************************************
  // one word clock cycle, 8 clk high, at least 10 clk low
  // ****************************************
  logic [4:0] ph_q;
  assign busy = (ph_q != 5'h00);
  // bad_par lets a scenario break lane parity on purpose
  assign parity_lane = ^data_lanes ^ bad_par;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      ph_q <= 5'h00;
      input_word_clock <= 1'b0;
      data_lanes <= 16'h0000;
      frame_marker <= 1'b0;
    end
    else if (ph_q == 5'h00)
    begin
      if (send)
      begin
        ph_q <= 5'h01;
        data_lanes <= word_r;
        frame_marker <= frame_r;
      end
    end
    else
    begin
      ph_q <= (ph_q == 5'h11) ? 5'h00 : ph_q + 5'h01;
      if (ph_q == 5'h05)
        input_word_clock <= 1'b1;
      if (ph_q == 5'h09)
      begin
        data_lanes <= word_f;
        frame_marker <= frame_f;
      end
      if (ph_q == 5'h0D)
        input_word_clock <= 1'b0;
      // hold over: lanes no longer carry the last value
      if (ph_q == 5'h11)
      begin
        data_lanes <= ~data_lanes;
        frame_marker <= ~frame_marker;
      end
    end
endmodule
`default_nettype wire

// [tb/lsp_lvds_rx_tb.sv]
// self-checking bench for the lvds sample input port
`timescale 1ns/1ps
`default_nettype none
module lsp_lvds_rx_tb;
  import lsp_pkg::*;
  logic clk, rst_b, chip_reset_n, sleep_pin, tx_gate_pin, cfg_load;
  logic cfg_word_mode, cfg_rev_bus, cfg_tx_gate, cfg_alarm_low;
  logic cfg_parity_chk, cfg_block_par, cfg_frame_sync, cfg_dual_sync;
  logic alarm_clear, converter_clock, output_strobe, send, bad, f_r, f_f;
  logic iwc, frm, par, busy, valid, fres, sev, algn, perr, txa, alm, pdn;
  logic [15:0] lanes;
  lsp_word_t w_r, w_f, i_s, q_s, e_i, e_q;
  logic [2:0] wrp, rdp;
  logic [1:0] divp;
  logic got_v, got_fr, got_sy, got_al;
  int fail_count = 0;
  int n_tests = 0;
  lsp_src_model src (.clk(clk), .rst_b(rst_b), .send(send), .word_r(w_r),
    .word_f(w_f), .frame_r(f_r), .frame_f(f_f), .bad_par(bad), .busy(busy),
    .input_word_clock(iwc), .data_lanes(lanes), .frame_marker(frm),
    .parity_lane(par));
  lsp_lvds_rx dut (.clk(clk), .rst_b(rst_b), .input_word_clock(iwc),
    .data_lanes(lanes), .frame_marker(frm), .parity_lane(par),
    .sync_lane(1'b0), .converter_clock(converter_clock),
    .output_strobe(output_strobe), .chip_reset_n(chip_reset_n),
    .sleep_pin(sleep_pin), .tx_gate_pin(tx_gate_pin), .cfg_load(cfg_load),
    .cfg_word_mode(cfg_word_mode), .cfg_rev_bus(cfg_rev_bus),
    .cfg_tx_gate(cfg_tx_gate), .cfg_alarm_low(cfg_alarm_low),
    .cfg_parity_chk(cfg_parity_chk), .cfg_block_par(cfg_block_par),
    .cfg_frame_sync(cfg_frame_sync), .cfg_dual_sync(cfg_dual_sync),
    .alarm_clear(alarm_clear), .i_sample_q(i_s), .q_sample_q(q_s),
    .sample_valid_q(valid), .fifo_reset_q(fres), .sync_event_q(sev),
    .wr_ptr_q(wrp), .rd_ptr(rdp), .div_phase(divp), .strobe_align(algn),
    .parity_err_q(perr), .tx_active(txa), .alarm_pin(alm),
    .power_down(pdn));
  // ****************************************
  // clock and pulse catchers
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pulses last one cycle, so they are latched here for later checks
  always @(posedge clk)
  begin
    if (valid === 1'b1) got_v <= 1'b1;
    if (fres === 1'b1) got_fr <= 1'b1;
    if (sev === 1'b1) got_sy <= 1'b1;
    if (algn === 1'b1) got_al <= 1'b1;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task automatic clr;
    got_v = 1'b0;
    got_fr = 1'b0;
    got_sy = 1'b0;
    got_al = 1'b0;
  endtask
  task automatic cfg(input logic [7:0] v);
    {cfg_word_mode, cfg_rev_bus, cfg_tx_gate, cfg_alarm_low, cfg_parity_chk,
     cfg_block_par, cfg_frame_sync, cfg_dual_sync} = v;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
    @(negedge clk);
  endtask
  task automatic xfer(input lsp_word_t r, f, input logic fr, ff, bp);
    int n = 0;
    w_r = r;
    w_f = f;
    f_r = fr;
    f_f = ff;
    bad = bp;
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
    while (busy !== 1'b0 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 40)
    begin
      $display("MISMATCH source busy expected 0 seen %b", busy);
      fail_count++;
      final_report();
    end
    repeat (6) @(negedge clk);
  endtask
  task automatic conv(input logic s);
    converter_clock = 1'b1;
    output_strobe = s;
    repeat (4) @(negedge clk);
    converter_clock = 1'b0;
    output_strobe = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  function automatic logic [7:0] sel8(input logic [7:0] b, input logic rv);
    sel8 = b;
    if (rv)
      for (int k = 0; k < 8; k++) sel8[k] = b[7-k];
  endfunction
  function automatic lsp_word_t sel16(input lsp_word_t b, input logic rv);
    sel16 = b;
    if (rv)
      for (int k = 0; k < 16; k++) sel16[k] = b[15-k];
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {chip_reset_n, cfg_word_mode, cfg_rev_bus, cfg_tx_gate} = 4'b1000;
    {cfg_alarm_low, cfg_parity_chk, cfg_block_par, cfg_frame_sync} = 4'h0;
    {cfg_dual_sync, cfg_load, alarm_clear, tx_gate_pin, send, bad} = 6'h00;
    {converter_clock, output_strobe, f_r, f_f} = 4'h0;
    w_r = 16'h0000;
    w_f = 16'h0000;
    rst_b = 1'b0;
    sleep_pin = 1'b1;
    clr();
    #1 check("power_down", pdn, 16'h0001);
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    sleep_pin = 1'b0;
    #1 check("power_down", pdn, 16'h0000);
    repeat (3) @(negedge clk);
    cfg(8'h80);
    check("tx_active", txa, 16'h0000);
    xfer(16'h1234, 16'h5678, 1'b0, 1'b0, 1'b0);
    check("valid gated", got_v, 16'h0000);
    check("i gated", i_s, 16'h0000);
    tx_gate_pin = 1'b1;
    repeat (4) @(negedge clk);
    check("tx_active pin", txa, 16'h0001);
    tx_gate_pin = 1'b0;
    for (int rv = 0; rv < 2; rv++)
    begin
      cfg({2'b10 | rv[1:0], 6'h20});
      clr();
      xfer(16'hA5C3, 16'h3C81, 1'b0, 1'b0, 1'b0);
      check("word valid", got_v, 16'h0001);
      check("word i", i_s, sel16(16'hA5C3, rv[0]));
      check("word q", q_s, sel16(16'h3C81, rv[0]));
      cfg({2'b00 | rv[1:0], 6'h20});
      clr();
      xfer(16'hF1B4, 16'h0E2D, 1'b1, 1'b0, 1'b0);
      xfer(16'h9A67, 16'h5C18, 1'b0, 1'b0, 1'b0);
      e_i = {sel8(8'hB4, rv[0]), sel8(8'h2D, rv[0])};
      e_q = {sel8(8'h67, rv[0]), sel8(8'h18, rv[0])};
      check("byte i", i_s, e_i);
      check("byte q", q_s, e_q);
    end
    for (int m = 0; m < 2; m++)
    begin
      cfg(8'hA0 | {6'h00, m[0], 1'b0});
      clr();
      xfer(16'h0F0F, 16'h00FF, 1'b1, 1'b0, 1'b0);
      check("fifo reset", got_fr, {15'h0000, ~m[0]});
      check("sync event", got_sy, {15'h0000, m[0]});
      if (m == 0) check("wr_ptr", wrp, 16'h0001);
    end
    cfg(8'hA4);
    xfer(16'h1357, 16'h2468, 1'b0, ^(16'h1357 ^ 16'h2468), 1'b0);
    check("block parity ok", perr, 16'h0000);
    xfer(16'h1357, 16'h2468, 1'b0, ~^(16'h1357 ^ 16'h2468), 1'b0);
    check("block parity bad", perr, 16'h0001);
    check("alarm high", alm, 16'h0001);
    cfg(8'hB4);
    check("alarm low", alm, 16'h0000);
    alarm_clear = 1'b1;
    @(negedge clk);
    alarm_clear = 1'b0;
    @(negedge clk);
    check("alarm cleared", alm, 16'h0001);
    cfg(8'hA0);
    xfer(16'h8001, 16'h7FFE, 1'b0, 1'b0, 1'b1);
    check("lane parity off", perr, 16'h0000);
    cfg(8'hA8);
    xfer(16'h8001, 16'h7FFE, 1'b0, 1'b0, 1'b0);
    check("lane parity ok", perr, 16'h0000);
    xfer(16'h8001, 16'h7FFE, 1'b0, 1'b0, 1'b1);
    check("lane parity bad", perr, 16'h0001);
    chip_reset_n = 1'b0;
    repeat (5) @(negedge clk);
    chip_reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check("chip reset gate", txa, 16'h0000);
    check("chip reset err", perr, 16'h0000);
    check("chip reset alarm", alm, 16'h0000);
    repeat (2) conv(1'b0);
    cfg(8'h01);
    clr();
    conv(1'b1);
    check("strobe align", got_al, 16'h0001);
    check("rd_ptr align", rdp, 16'h0000);
    check("div align", divp, 16'h0000);
    repeat (4) conv(1'b0);
    check("div wrap", divp, 16'h0000);
    check("rd_ptr step", rdp, 16'h0001);
    cfg(8'h00);
    clr();
    conv(1'b1);
    check("strobe single", got_al, 16'h0000);
    check("div single", divp, 16'h0001);
    final_report();
  end
endmodule
`default_nettype wire
